// *** pkg/dag_pkg.sv ***
// package: register map, field layout and carriers of the address unit
package dag_pkg;
  localparam int AW = 4;
  localparam logic [AW-1:0] REG_MODE_CTRL  = 4'h0;
  localparam logic [AW-1:0] REG_REV_CTRL   = 4'h1;
  localparam logic [AW-1:0] REG_TABLE_PAGE = 4'h2;
  localparam logic [AW-1:0] REG_VIS_PAGE   = 4'h3;
  localparam logic [AW-1:0] REG_X_START    = 4'h4;
  localparam logic [AW-1:0] REG_X_END      = 4'h5;
  localparam logic [AW-1:0] REG_Y_START    = 4'h6;
  localparam logic [AW-1:0] REG_Y_END      = 4'h7;
  localparam int X_SEL_LSB   = 0;
  localparam int Y_SEL_LSB   = 4;
  localparam int REV_SEL_LSB = 8;
  localparam int Y_EN_BIT    = 14;
  localparam int X_EN_BIT    = 15;
  localparam int REV_EN_BIT  = 15;
  localparam int PAGE_CFG_BIT = 7;
  localparam logic [3:0]  SEL_OFF = 4'hf;
  localparam logic [15:0] MODE_CTRL_RST  = 16'h0fff;
  localparam logic [15:0] REV_CTRL_RST   = 16'h0000;
  localparam logic [7:0]  PAGE_RST       = 8'h00;
  localparam logic [15:0] BOUND_RST      = 16'h0000;

  typedef enum logic [1:0] {
    DAG_X_READ,
    DAG_X_WRITE,
    DAG_Y_ACCESS
  } dag_space_t;

  typedef enum logic [2:0] {
    DAG_INDIRECT,
    DAG_POST_INC,
    DAG_POST_DEC,
    DAG_PRE_INC,
    DAG_PRE_DEC,
    DAG_REG_OFFSET
  } dag_mode_t;

  typedef struct packed {
    logic       valid;
    dag_space_t space;
    dag_mode_t  mode;
    logic       byte_acc;
    logic [3:0] ptr_sel;
    logic [15:0] ptr;
    logic [15:0] step;
  } dag_addr_req_t;

  typedef struct packed {
    logic        valid;
    logic [15:0] ea;
    logic        wb_en;
    logic [3:0]  wb_sel;
    logic [15:0] wb_val;
    logic        circular;
    logic        reversed;
  } dag_addr_rsp_t;

  typedef struct packed {
    logic        valid;
    logic [15:0] ea;
    logic        table_acc;
    logic        vis_en;
    logic        write;
  } dag_prog_req_t;

  typedef struct packed {
    logic        valid;
    logic [23:0] addr;
    logic        config_space;
    logic        low_word_only;
    logic        refused;
  } dag_prog_rsp_t;
endpackage

// *** logic/dag_top.sv ***
// address unit: circular, bit-reversed and program space addressing
// Function
// [RULE1] x select 15 turns off x circular
// [RULE2] x circular needs select not 15, enable
// [RULE3] y circular needs select not 15, enable
// [RULE4] bounds test is beyond, not equal
// [RULE5] write back only on pre/post modify
// [RULE6] bit reversal only for x writes
// [RULE7] only the modifier is bit reversed
// [RULE8] reversal needs select, enable, pre/post increment
// [RULE9] software aligns reversed buffer to size
// [RULE10] 15-bit pivot scaled to byte address
// [RULE11] byte or other modes get normal address
// [RULE12] reversal adds pivot, drops step, clears lsb
// [RULE13] reversal beats circular in x write
// [RULE14] software avoids read right after control write
// [RULE15] table address is page over ea
// [RULE16] visibility address is page over ea low
// [RULE17] visibility bit 15 is page bit 0
// [RULE18] visibility is read only, low word
// [RULE19] four 16-bit circular bound registers
// [RULE20] y circular addresses keep lsb clear
// [RULE21] reversed add carries downward
`timescale 1ns/1ps
module dag_top
  import dag_pkg::*;
(
  // clock and reset
  input  wire logic            clk_in,
  input  wire logic            rst_n_in,
  // register port
  input  wire logic [dag_pkg::AW-1:0] reg_addr_in,
  input  wire logic [15:0]     reg_wdata_in,
  input  wire logic            reg_wr_in,
  input  wire logic            reg_rd_in,
  output logic [15:0]          reg_rdata_out,
  // data address request and answer
  input  wire dag_pkg::dag_addr_req_t addr_req_in,
  output dag_pkg::dag_addr_rsp_t      addr_rsp_out,
  // program address request and answer
  input  wire dag_pkg::dag_prog_req_t prog_req_in,
  output dag_pkg::dag_prog_rsp_t      prog_rsp_out
);
  import dag_pkg::*;

  logic [15:0] mode_ctrl;
  logic [15:0] rev_ctrl;
  logic [7:0]  table_page;
  logic [7:0]  vis_page;
  logic [15:0] x_start;
  logic [15:0] x_end;
  logic [15:0] y_start;
  logic [15:0] y_end;

  function automatic logic [15:0] rev16(input logic [15:0] v);
    logic [15:0] r;
    r = 16'h0000;
    for (int i = 0; i < 16; i++)
      r[i] = v[15-i];
    return r;
  endfunction

  // wrap an address that went past either bound
  function automatic logic [15:0] wrap(
    input logic [15:0] a,
    input logic [15:0] lo,
    input logic [15:0] hi
  );
    logic [15:0] len;
    len = 16'(hi - lo + 16'h0001);
    if (a > hi)                     // RULE4
      return 16'(a - len);
    else if (a < lo)                // RULE4
      return 16'(a + len);
    else
      return a;
  endfunction

  // register port
  wire wr_mode  = reg_wr_in && reg_addr_in == REG_MODE_CTRL;
  wire wr_rev   = reg_wr_in && reg_addr_in == REG_REV_CTRL;
  wire wr_tpage = reg_wr_in && reg_addr_in == REG_TABLE_PAGE;
  wire wr_vpage = reg_wr_in && reg_addr_in == REG_VIS_PAGE;
  wire wr_xs    = reg_wr_in && reg_addr_in == REG_X_START;
  wire wr_xe    = reg_wr_in && reg_addr_in == REG_X_END;
  wire wr_ys    = reg_wr_in && reg_addr_in == REG_Y_START;
  wire wr_ye    = reg_wr_in && reg_addr_in == REG_Y_END;

  logic [15:0] rd_mux;
  always_comb
  begin
    unique case (reg_addr_in)
      REG_MODE_CTRL:  rd_mux = mode_ctrl;
      REG_REV_CTRL:   rd_mux = rev_ctrl;
      REG_TABLE_PAGE: rd_mux = {8'h00, table_page};
      REG_VIS_PAGE:   rd_mux = {8'h00, vis_page};
      REG_X_START:    rd_mux = x_start;
      REG_X_END:      rd_mux = x_end;
      REG_Y_START:    rd_mux = y_start;
      REG_Y_END:      rd_mux = y_end;
      default:        rd_mux = 16'h0000;
    endcase
  end

  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      mode_ctrl  <= MODE_CTRL_RST;
      rev_ctrl   <= REV_CTRL_RST;
      table_page <= PAGE_RST;
      vis_page   <= PAGE_RST;
    end
    else
    begin
      if (wr_mode)
        mode_ctrl <= reg_wdata_in;
      if (wr_rev)
        rev_ctrl <= reg_wdata_in;
      if (wr_tpage)
        table_page <= reg_wdata_in[7:0];
      if (wr_vpage)
        vis_page <= reg_wdata_in[7:0];
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      x_start <= BOUND_RST;
      x_end   <= BOUND_RST;
      y_start <= BOUND_RST;
      y_end   <= BOUND_RST;
    end
    else
    begin
      if (wr_xs)
        x_start <= reg_wdata_in;    // RULE19
      if (wr_xe)
        x_end <= reg_wdata_in;      // RULE19
      if (wr_ys)
        y_start <= reg_wdata_in;    // RULE19
      if (wr_ye)
        y_end <= reg_wdata_in;      // RULE19
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      reg_rdata_out <= 16'h0000;
    else if (reg_rd_in)
      reg_rdata_out <= rd_mux;
    else
      reg_rdata_out <= 16'h0000;
  end

  // control fields
  wire [3:0] x_sel   = mode_ctrl[X_SEL_LSB +: 4];
  wire [3:0] y_sel   = mode_ctrl[Y_SEL_LSB +: 4];
  wire [3:0] rev_sel = mode_ctrl[REV_SEL_LSB +: 4];
  wire       x_on    = x_sel != SEL_OFF && mode_ctrl[X_EN_BIT]; // RULE1 RULE2
  wire       y_on    = y_sel != SEL_OFF && mode_ctrl[Y_EN_BIT]; // RULE3
  wire       rev_on  = rev_sel != SEL_OFF && rev_ctrl[REV_EN_BIT]; // RULE8
  wire [15:0] pivot  = {rev_ctrl[14:0], 1'b0};   // RULE10

  // data address request decode
  dag_addr_req_t rq;
  assign rq = addr_req_in;
  wire is_pre  = rq.mode == DAG_PRE_INC || rq.mode == DAG_PRE_DEC;
  wire is_post = rq.mode == DAG_POST_INC || rq.mode == DAG_POST_DEC;
  wire is_inc  = rq.mode == DAG_PRE_INC || rq.mode == DAG_POST_INC;
  wire is_dec  = rq.mode == DAG_PRE_DEC || rq.mode == DAG_POST_DEC;
  wire is_off  = rq.mode == DAG_REG_OFFSET;
  wire is_x    = rq.space != DAG_Y_ACCESS;

  // reversal: x write unit, word data, pre/post increment only
  wire use_rev = rev_on && rq.space == DAG_X_WRITE  // RULE6
              && rq.ptr_sel == rev_sel && is_inc    // RULE8
              && !rq.byte_acc;                      // RULE11

  // circular: x units share bounds, x write yields to reversal
  wire use_x_circ = x_on && is_x && rq.ptr_sel == x_sel
                 && !use_rev;                       // RULE13
  wire use_y_circ = y_on && !is_x && rq.ptr_sel == y_sel; // RULE3
  wire use_circ   = use_x_circ || use_y_circ;

  wire [15:0] lo = use_y_circ ? y_start : x_start;
  wire [15:0] hi = use_y_circ ? y_end : x_end;

  wire [15:0] stepped = is_dec ? 16'(rq.ptr - rq.step)
                               : 16'(rq.ptr + rq.step);
  wire [15:0] wrapped = wrap(stepped, lo, hi);
  // y circular assumes word data
  wire [15:0] circ_val = use_y_circ ? {wrapped[15:1], 1'b0} // RULE20
                                    : wrapped;
  wire [15:0] normal_val = use_circ ? circ_val : stepped;

  // modifier reversed, pointer in normal order, carries run downward
  wire [15:0] rev_sum = rev16(16'(rev16(rq.ptr) + rev16(pivot))); // RULE7 RULE21
  wire [15:0] rev_val = {rev_sum[15:1], 1'b0};   // RULE12

  wire [15:0] mod_val = use_rev ? rev_val : normal_val; // RULE12 RULE11

  logic [15:0] next_ea;
  always_comb
  begin
    if (is_pre || is_off)
      next_ea = mod_val;
    else
      next_ea = rq.ptr;
  end

  dag_addr_rsp_t next_rsp;
  always_comb
  begin
    next_rsp          = '0;
    next_rsp.valid    = rq.valid;
    next_rsp.ea       = next_ea;
    next_rsp.wb_en    = rq.valid && (is_pre || is_post); // RULE5
    next_rsp.wb_sel   = rq.ptr_sel;
    next_rsp.wb_val   = (is_pre || is_post) ? mod_val : rq.ptr; // RULE5
    next_rsp.circular = rq.valid && use_circ
                     && (is_pre || is_post || is_off);
    next_rsp.reversed = rq.valid && use_rev;
  end

  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      addr_rsp_out <= '0;
    else
      addr_rsp_out <= next_rsp;
  end

  // program space address construction
  dag_prog_req_t pq;
  assign pq = prog_req_in;
  wire vis_map = !pq.table_acc && pq.vis_en && pq.ea[15];
  wire vis_bad = vis_map && pq.write;               // RULE18
  wire [23:0] tbl_addr = {table_page, pq.ea};       // RULE15
  // ea bit 15 is dropped, page bit 0 takes its place
  wire [23:0] vis_addr = {1'b0, vis_page, pq.ea[14:0]}; // RULE16 RULE17

  dag_prog_rsp_t next_prog;
  always_comb
  begin
    next_prog               = '0;
    next_prog.valid         = pq.valid && (pq.table_acc || vis_map)
                           && !vis_bad;
    next_prog.addr          = pq.table_acc ? tbl_addr : vis_addr;
    next_prog.config_space  = pq.table_acc
                           && table_page[PAGE_CFG_BIT]; // RULE15
    // a refused write carries no data word, so no low-word mark either
    next_prog.low_word_only = pq.valid && vis_map && !vis_bad; // RULE18
    next_prog.refused       = pq.valid && vis_bad;  // RULE18
    if (!next_prog.valid)
      next_prog.addr = 24'h000000;
  end

  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      prog_rsp_out <= '0;
    else
      prog_rsp_out <= next_prog;
  end
endmodule

// *** tb/dag_properties.sv ***
// checker of the address unit ports
`timescale 1ns/1ps
module dag_properties
  import dag_pkg::*;
(
  // clock, reset and register port
  input wire logic                   clk_in,
  input wire logic                   rst_n_in,
  input wire logic [dag_pkg::AW-1:0] reg_addr_in,
  input wire logic [15:0]            reg_wdata_in,
  input wire logic                   reg_wr_in,
  input wire logic                   reg_rd_in,
  input wire logic [15:0]            reg_rdata_out,
  // address requests and answers
  input wire dag_pkg::dag_addr_req_t addr_req_in,
  input wire dag_pkg::dag_addr_rsp_t addr_rsp_out,
  input wire dag_pkg::dag_prog_req_t prog_req_in,
  input wire dag_pkg::dag_prog_rsp_t prog_rsp_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  logic [15:0]   m_sh;
  logic [15:0]   r_sh;
  logic [7:0]    t_sh;
  logic [7:0]    v_sh;
  wire dag_addr_req_t q = addr_req_in;
  wire dag_addr_rsp_t r = addr_rsp_out;
  wire dag_prog_req_t p = prog_req_in;
  wire dag_prog_rsp_t g = prog_rsp_out;
  wire [14:0]    ea_lo = p.ea[14:0];
  wire           vis = p.valid && !p.table_acc && p.vis_en && p.ea[15];
  wire           inc = q.mode == DAG_PRE_INC || q.mode == DAG_POST_INC;
  wire           rv_ok = q.valid && q.space == DAG_X_WRITE && inc
    && !q.byte_acc && r_sh[REV_EN_BIT] && m_sh[11:8] != SEL_OFF
    && q.ptr_sel == m_sh[11:8];
  wire           x_ok = m_sh[X_EN_BIT] && m_sh[3:0] != SEL_OFF
    && q.ptr_sel == m_sh[3:0];
  wire           y_ok = m_sh[Y_EN_BIT] && m_sh[7:4] != SEL_OFF
    && q.ptr_sel == m_sh[7:4];
  // shadow copies of the control registers
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      m_sh <= MODE_CTRL_RST;
      r_sh <= REV_CTRL_RST;
      t_sh <= PAGE_RST;
      v_sh <= PAGE_RST;
    end
    else
    begin
      if (reg_wr_in && reg_addr_in == REG_MODE_CTRL) m_sh <= reg_wdata_in;
      if (reg_wr_in && reg_addr_in == REG_REV_CTRL) r_sh <= reg_wdata_in;
      if (reg_wr_in && reg_addr_in == REG_TABLE_PAGE)
        t_sh <= reg_wdata_in[7:0];
      if (reg_wr_in && reg_addr_in == REG_VIS_PAGE)
        v_sh <= reg_wdata_in[7:0];
    end
  end
  a_rev_enable: assert property (r.reversed == $past(rv_ok))
    else $error("reversal flag wrong");
  a_rev_no_circ: assert property (r.reversed |-> !r.circular)
    else $error("circular during reversal");
  a_x_circ_cond: assert property (r.circular && $past(q.space) !=
    DAG_Y_ACCESS |-> $past(x_ok)) else $error("x circular wrongly on");
  a_y_circ_cond: assert property (r.circular && $past(q.space) ==
    DAG_Y_ACCESS |-> $past(y_ok) && !(r.wb_en && r.wb_val[0]))
    else $error("y circular wrong");
  a_wb_modes: assert property (r.valid |-> r.wb_en == $past(inc
    || q.mode == DAG_PRE_DEC || q.mode == DAG_POST_DEC))
    else $error("write back wrong");
  a_table_addr: assert property ($past(p.valid && p.table_acc) |->
    g.valid && g.addr == {$past(t_sh), $past(p.ea)}
    && g.config_space == $past(t_sh[7])) else $error("table addr wrong");
  a_vis_addr: assert property ($past(vis && !p.write) |-> g.valid
    && g.low_word_only && g.addr == {1'b0, $past(v_sh), $past(ea_lo)})
    else $error("visibility addr wrong");
  a_vis_write: assert property ($past(vis && p.write) |->
    !g.valid && g.refused) else $error("visibility write taken");
endmodule
bind dag_top dag_properties u_props (.*);

// *** tb/dag_core_model.sv ***
// core side model: issues data and program address requests
`timescale 1ns/1ps
module dag_core_model
  import dag_pkg::*;
(
  // clock
  input  wire logic              clk_in,
  // requests toward the address unit
  output dag_pkg::dag_addr_req_t addr_req_out,
  output dag_pkg::dag_prog_req_t prog_req_out
);
  initial
  begin
    addr_req_out = '0;
    prog_req_out = '0;
  end
  // one edge per request, then scrambled fields
  task automatic put_addr(input dag_addr_req_t r);
    dag_addr_req_t idle;
    idle = ~r;
    idle.valid = 1'b0;
    addr_req_out <= r;
    @(posedge clk_in);
    addr_req_out <= idle;
  endtask
  task automatic put_prog(input dag_prog_req_t r);
    dag_prog_req_t idle;
    idle = ~r;
    idle.valid = 1'b0;
    prog_req_out <= r;
    @(posedge clk_in);
    prog_req_out <= idle;
  endtask
endmodule

// *** tb/tb.sv ***
// testbench of the address unit
`timescale 1ns/1ps
module tb;
  import dag_pkg::*;
  localparam dag_space_t XR = DAG_X_READ;
  localparam dag_space_t XW = DAG_X_WRITE;
  localparam dag_space_t YA = DAG_Y_ACCESS;
  logic          clk_in;
  logic          rst_n_in;
  logic          reg_wr_in;
  logic          reg_rd_in;
  logic [AW-1:0] reg_addr_in;
  logic [15:0]   reg_wdata_in;
  logic [15:0]   reg_rdata_out;
  dag_addr_req_t aq;
  dag_addr_rsp_t ar;
  dag_prog_req_t pq;
  dag_prog_rsp_t pr;
  int            n_fail;
  int            checks_done;
  int            cycles;
  dag_top uut (.clk_in(clk_in), .rst_n_in(rst_n_in),
    .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in),
    .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
    .reg_rdata_out(reg_rdata_out), .addr_req_in(aq), .addr_rsp_out(ar),
    .prog_req_in(pq), .prog_rsp_out(pr));
  dag_core_model core (.clk_in(clk_in), .addr_req_out(aq),
    .prog_req_out(pq));
  initial
  begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end
  always @(posedge clk_in)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      n_fail++;
      print_verdict();
    end
  end
  task automatic chk(input string n, input logic [39:0] e, s);
    checks_done++;
    if (s !== e)
    begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic wr(input logic [AW-1:0] a, input logic [15:0] d);
    @(posedge clk_in);
    reg_wr_in <= 1'b1;
    reg_addr_in <= a;
    reg_wdata_in <= d;
    @(posedge clk_in);
    reg_wr_in <= 1'b0;
  endtask
  task automatic rd(input logic [AW-1:0] a, input logic [15:0] e);
    @(posedge clk_in);
    reg_rd_in <= 1'b1;
    reg_addr_in <= a;
    @(posedge clk_in);
    reg_rd_in <= 1'b0;
    #1 chk("register", {24'h0, e}, {24'h0, reg_rdata_out});
  endtask
  // bs is byte flag over pointer select
  task automatic ad(input dag_space_t sp, input dag_mode_t m,
    input logic [4:0] bs, input logic [15:0] p, st, e, wv,
    input logic w, rv);
    @(posedge clk_in);
    core.put_addr('{1'b1, sp, m, bs[4], bs[3:0], p, st});
    #1 chk("data addr", {1'b0, bs[3:0], 1'b1, e, wv, w, rv},
      {1'b0, ar.wb_sel, ar.valid, ar.ea,
      ar.wb_en ? ar.wb_val : 16'h0, ar.wb_en, ar.reversed});
  endtask
  task automatic pg(input logic [15:0] ea, input logic t, v, w,
    input logic [27:0] e);
    @(posedge clk_in);
    core.put_prog('{1'b1, ea, t, v, w});
    #1 chk("prog addr", {12'h0, e}, {12'h0, pr.valid, pr.valid ? pr.addr
      : 24'h0, pr.config_space, pr.low_word_only, pr.refused});
  endtask
  function automatic logic [15:0] rv16(input logic [15:0] v);
    for (int i = 0; i < 16; i++)
      rv16[i] = v[15-i];
  endfunction
  task automatic t_regs();
    for (int i = 0; i < 9; i++)
      rd(4'(i), i == 0 ? MODE_CTRL_RST : 16'h0);
    for (int i = 0; i < 9; i++)
      wr(4'(i), 16'h5ac3 + 16'(i));
    for (int i = 0; i < 9; i++)
      rd(4'(i), i == 8 ? 16'h0 : i inside {2, 3} ? 16'hc3 + 16'(i)
        : 16'h5ac3 + 16'(i));
  endtask
  task automatic t_circ();
    wr(REG_X_START, 16'h100);
    wr(REG_X_END, 16'h11f);
    wr(REG_Y_START, 16'h200);
    wr(REG_Y_END, 16'h21f);
    wr(REG_MODE_CTRL, 16'hcf32);
    ad(XR, DAG_POST_INC, 5'h2, 16'h11e, 16'h4, 16'h11e, 16'h102, 1, 0);
    ad(XR, DAG_PRE_DEC, 5'h2, 16'h100, 16'h2, 16'h11e, 16'h11e, 1, 0);
    ad(XR, DAG_PRE_INC, 5'h2, 16'h11d, 16'h2, 16'h11f, 16'h11f, 1, 0);
    ad(XR, DAG_REG_OFFSET, 5'h2, 16'h11e, 16'h4, 16'h102, 16'h0, 0, 0);
    ad(XW, DAG_POST_INC, 5'h5, 16'h11e, 16'h4, 16'h11e, 16'h122, 1, 0);
    ad(YA, DAG_POST_INC, 5'h3, 16'h21e, 16'h3, 16'h21e, 16'h200, 1, 0);
    wr(REG_MODE_CTRL, 16'hcf3f);
    ad(XR, DAG_POST_INC, 5'hf, 16'h11e, 16'h4, 16'h11e, 16'h122, 1, 0);
    wr(REG_MODE_CTRL, 16'h4f32);
    ad(XR, DAG_POST_INC, 5'h2, 16'h11e, 16'h4, 16'h11e, 16'h122, 1, 0);
    wr(REG_MODE_CTRL, 16'h8f32);
    ad(YA, DAG_POST_INC, 5'h3, 16'h21e, 16'h4, 16'h21e, 16'h222, 1, 0);
  endtask
  task automatic t_rev();
    logic [15:0] p;
    logic [15:0] n;
    wr(REG_REV_CTRL, 16'h8008);
    wr(REG_MODE_CTRL, 16'h84f4);
    p = 16'h1000;
    repeat (4)
    begin
      n = rv16(rv16(p) + rv16(16'h10));
      ad(XW, DAG_POST_INC, 5'h4, p, 16'h2, p, n, 1, 1);
      p = n;
    end
    ad(XW, DAG_PRE_INC, 5'h4, 16'h1000, 16'h2, 16'h1010, 16'h1010, 1, 1);
    ad(XR, DAG_POST_INC, 5'h4, 16'h11e, 16'h4, 16'h11e, 16'h102, 1, 0);
    ad(XW, DAG_POST_INC, 5'h14, 16'h104, 16'h1, 16'h104, 16'h105, 1, 0);
    ad(XW, DAG_POST_DEC, 5'h4, 16'h104, 16'h2, 16'h104, 16'h102, 1, 0);
    ad(XW, DAG_POST_INC, 5'h6, 16'h1000, 16'h2, 16'h1000, 16'h1002, 1, 0);
    wr(REG_REV_CTRL, 16'h0008);
    ad(XW, DAG_POST_INC, 5'h4, 16'h104, 16'h2, 16'h104, 16'h106, 1, 0);
    wr(REG_REV_CTRL, 16'h8008);
    wr(REG_MODE_CTRL, 16'h0ff4);
    ad(XW, DAG_POST_INC, 5'hf, 16'h1000, 16'h2, 16'h1000, 16'h1002, 1, 0);
  endtask
  task automatic t_prog();
    wr(REG_TABLE_PAGE, 16'h85);
    wr(REG_VIS_PAGE, 16'h3b);
    pg(16'h1234, 1, 1, 0, {1'b1, 24'h851234, 3'b100});
    pg(16'h9abc, 0, 1, 0, {1'b1, 24'h1d9abc, 3'b010});
    pg(16'h9abc, 0, 1, 1, {1'b0, 24'h0, 3'b001});
    pg(16'h1abc, 0, 1, 0, 28'h0);
    wr(REG_TABLE_PAGE, 16'h05);
    pg(16'h8001, 1, 1, 1, {1'b1, 24'h058001, 3'b000});
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  initial
  begin
    n_fail = 0;
    checks_done = 0;
    cycles = 0;
    rst_n_in = 1'b0;
    reg_wr_in = 1'b0;
    reg_rd_in = 1'b0;
    reg_addr_in = '0;
    reg_wdata_in = 16'h0;
    repeat (5) @(posedge clk_in);
    rst_n_in <= 1'b1;
    t_regs();
    t_circ();
    t_rev();
    t_prog();
    print_verdict();
  end
endmodule
